// ==== hdl/mcst_pkg.sv ====
// Package of constants and carriers for the module control and status timing block
package mcst_pkg;
   // Clock rate in kHz (200 MHz)
   localparam int unsigned CLK_KHZ              = 200000;
   // Printed times, each in its own unit
   localparam int unsigned LASER_OFF_TIME_US    = 100;
   localparam int unsigned LASER_ON_TIME_MS     = 2;
   localparam int unsigned MGMT_READY_TIME_MS   = 300;
   localparam int unsigned STARTUP_TIME_MS      = 300;
   localparam int unsigned STARTUP_COOLED_S     = 90;
   localparam int unsigned HIGH_POWER_TIME_MS   = 300;
   localparam int unsigned LOW_POWER_TIME_MS    = 300;
   localparam int unsigned FAULT_ON_TIME_MS     = 1;
   localparam int unsigned FAULT_ON_COOLED_MS   = 50;
   localparam int unsigned FAULT_RESET_TIME_US  = 10;
   localparam int unsigned RATE_FC_TIME_US      = 500;
   localparam int unsigned RATE_OTHER_TIME_MS   = 10;
   localparam int unsigned LOS_ON_TIME_US       = 100;
   localparam int unsigned LOS_OFF_TIME_US      = 100;
   // Cycle counts: longest times round down, least times round up
   localparam longint unsigned LASER_OFF_CYC    = longint'(LASER_OFF_TIME_US) * CLK_KHZ / 1000;
   localparam longint unsigned LASER_ON_CYC     = longint'(LASER_ON_TIME_MS) * CLK_KHZ;
   localparam longint unsigned MGMT_READY_CYC   = longint'(MGMT_READY_TIME_MS) * CLK_KHZ;
   localparam longint unsigned STARTUP_CYC      = longint'(STARTUP_TIME_MS) * CLK_KHZ;
   localparam longint unsigned STARTUP_COOL_CYC = longint'(STARTUP_COOLED_S) * CLK_KHZ * 1000;
   localparam longint unsigned HIGH_POWER_CYC   = longint'(HIGH_POWER_TIME_MS) * CLK_KHZ;
   localparam longint unsigned LOW_POWER_CYC    = longint'(LOW_POWER_TIME_MS) * CLK_KHZ;
   localparam longint unsigned FAULT_ON_CYC     = longint'(FAULT_ON_TIME_MS) * CLK_KHZ;
   localparam longint unsigned FAULT_COOL_CYC   = longint'(FAULT_ON_COOLED_MS) * CLK_KHZ;
   localparam longint unsigned FAULT_RESET_CYC  = (longint'(FAULT_RESET_TIME_US) * CLK_KHZ + 999) / 1000;
   localparam longint unsigned RATE_FC_CYC      = longint'(RATE_FC_TIME_US) * CLK_KHZ / 1000;
   localparam longint unsigned RATE_OTHER_CYC   = longint'(RATE_OTHER_TIME_MS) * CLK_KHZ;
   localparam longint unsigned LOS_ON_CYC       = longint'(LOS_ON_TIME_US) * CLK_KHZ / 1000;
   localparam longint unsigned LOS_OFF_CYC      = longint'(LOS_OFF_TIME_US) * CLK_KHZ / 1000;
   // Width of the shared delay counters
   localparam int unsigned CNT_W                = 35;

   typedef enum logic [2:0] {
      MCST_ST_OFF     = 3'b000,
      MCST_ST_STARTUP = 3'b001,
      MCST_ST_RUN     = 3'b010,
      MCST_ST_FAULT   = 3'b011,
      MCST_ST_DISABLE = 3'b100
   } mcst_laser_e;

   // Pin-level controls from the host
   typedef struct packed {
      logic laser_off_req;
      logic rate_select_low_bit;
      logic rate_select_high_bit;
      logic rate_is_fc;
      logic high_power_req;
   } mcst_ctrl_s;

   // Status seen by the host
   typedef struct packed {
      logic laser_en;
      logic tx_fault;
      logic rx_los;
      logic mgmt_ready;
      logic module_ready;
      logic rate_stable;
      logic high_power_on;
   } mcst_stat_s;
endpackage

// ==== hdl/mcst_delay.sv ====
// Qualifying delay: output follows input once input has held steady for the load count
module mcst_delay
   import mcst_pkg::*;
#(
   parameter int unsigned W = CNT_W
) (
   input  wire logic         mclk_i,
   input  wire logic         sys_rst_i,
   input  wire logic         rst_val_i,
   input  wire logic         in_i,
   input  wire logic [W-1:0] rise_cnt_i,
   input  wire logic [W-1:0] fall_cnt_i,
   output logic              out_o
);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic         next_out;
   logic         rst_seen;

   always_comb begin
      next_cnt = cnt;
      next_out = out_o;
      if (in_i == out_o) begin
         next_cnt = '0;
      end else if (cnt + W'(1) >= (in_i ? rise_cnt_i : fall_cnt_i)) begin
         next_cnt = '0;
         next_out = in_i;
      end else begin
         next_cnt = cnt + W'(1);
      end
   end

   // Reset takes a constant; the reset value is loaded on the first edge after release
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cnt      <= '0;
         out_o    <= 1'b0;
         rst_seen <= 1'b0;
      end else if (!rst_seen) begin
         cnt      <= '0;
         out_o    <= rst_val_i;
         rst_seen <= 1'b1;
      end else begin
         cnt      <= next_cnt;
         out_o    <= next_out;
      end
   end
endmodule

// ==== hdl/mcst_core.sv ====
// Control and status timing of a pluggable optical transceiver, module side
module mcst_core
   import mcst_pkg::*;
#(
   parameter bit             COOLED       = 1'b0,
   parameter longint unsigned LASER_ON    = LASER_ON_CYC,
   parameter longint unsigned MGMT_READY  = MGMT_READY_CYC,
   parameter longint unsigned STARTUP     = STARTUP_CYC,
   parameter longint unsigned STARTUP_COOL = STARTUP_COOL_CYC,
   parameter longint unsigned HIGH_POWER  = HIGH_POWER_CYC,
   parameter longint unsigned LOW_POWER   = LOW_POWER_CYC,
   parameter longint unsigned FAULT_ON    = FAULT_ON_CYC,
   parameter longint unsigned FAULT_COOL  = FAULT_COOL_CYC,
   parameter longint unsigned RATE_OTHER  = RATE_OTHER_CYC
) (
   input  wire logic              mclk_i,
   input  wire logic              sys_rst_i,
   input  wire mcst_pkg::mcst_ctrl_s ctrl_i,
   input  wire logic              laser_fault_i,
   input  wire logic              rx_signal_lost_i,
   output mcst_pkg::mcst_stat_s   stat_o,
   output logic                   tx_fault_oe_n_o
);
   import mcst_pkg::*;

   localparam logic [CNT_W-1:0] LASER_ON_W  = CNT_W'(LASER_ON);
   localparam logic [CNT_W-1:0] MGMT_W      = CNT_W'(MGMT_READY);
   localparam logic [CNT_W-1:0] START_W     = COOLED ? CNT_W'(STARTUP_COOL) : CNT_W'(STARTUP);
   localparam logic [CNT_W-1:0] HIGH_W      = CNT_W'(HIGH_POWER);
   localparam logic [CNT_W-1:0] LOW_W       = CNT_W'(LOW_POWER);
   localparam logic [CNT_W-1:0] FAULT_W     = COOLED ? CNT_W'(FAULT_COOL) : CNT_W'(FAULT_ON);
   localparam logic [CNT_W-1:0] FRST_W      = CNT_W'(FAULT_RESET_CYC);
   localparam logic [CNT_W-1:0] RATE_FC_W   = CNT_W'(RATE_FC_CYC);
   localparam logic [CNT_W-1:0] RATE_OT_W   = CNT_W'(RATE_OTHER);
   localparam logic [CNT_W-1:0] LOS_ON_W    = CNT_W'(LOS_ON_CYC);
   localparam logic [CNT_W-1:0] LOS_OFF_W   = CNT_W'(LOS_OFF_CYC);

   mcst_laser_e      state;
   mcst_laser_e      next_state;
   logic [CNT_W-1:0] tmr;
   logic [CNT_W-1:0] next_tmr;
   logic [CNT_W-1:0] mgmt_tmr;
   logic [CNT_W-1:0] next_mgmt_tmr;
   logic [CNT_W-1:0] dis_tmr;
   logic [CNT_W-1:0] next_dis_tmr;
   logic [CNT_W-1:0] rate_tmr;
   logic [CNT_W-1:0] next_rate_tmr;
   logic [CNT_W-1:0] pwr_tmr;
   logic [CNT_W-1:0] next_pwr_tmr;
   logic             laser_en;
   logic             next_laser_en;
   logic             fault_flag;
   logic             next_fault_flag;
   logic             mgmt_ready;
   logic             next_mgmt_ready;
   logic             rate_stable;
   logic             next_rate_stable;
   logic             hp_on;
   logic             next_hp_on;
   logic             hp_req_q;
   logic [1:0]       rate_q;
   logic             fault_seen;
   logic             los_flag;
   logic             fault_reset;

   // Fault must persist for the assert window; a shorter glitch is filtered
   mcst_delay #(.W(CNT_W)) u_fault_dly (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .rst_val_i (1'b0),
      .in_i      (laser_fault_i),
      .rise_cnt_i(FAULT_W),
      .fall_cnt_i(CNT_W'(1)),
      .out_o     (fault_seen)
   );

   // Loss flag starts asserted until signal presence is qualified
   mcst_delay #(.W(CNT_W)) u_los_dly (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .rst_val_i (1'b1),
      .in_i      (rx_signal_lost_i),
      .rise_cnt_i(LOS_ON_W),
      .fall_cnt_i(LOS_OFF_W),
      .out_o     (los_flag)
   );

   // Laser-off held long enough counts as a fault reset pulse
   // The edge that sees the last qualifying cycle counts, so a pulse of exactly the minimum clears
   assign fault_reset = ctrl_i.laser_off_req && (dis_tmr + CNT_W'(1) >= FRST_W);

   always_comb begin
      next_dis_tmr = '0;
      if (ctrl_i.laser_off_req) begin
         next_dis_tmr = (dis_tmr >= FRST_W) ? dis_tmr : dis_tmr + CNT_W'(1);
      end
   end

   // Laser state machine
   always_comb begin
      next_state      = state;
      next_tmr        = tmr + CNT_W'(1);
      next_laser_en   = laser_en;
      next_fault_flag = fault_flag;
      case (state)
         MCST_ST_OFF: begin
            next_laser_en = 1'b0;
            next_tmr      = '0;
            if (!ctrl_i.laser_off_req) begin
               next_state = MCST_ST_STARTUP;
            end
         end
         MCST_ST_STARTUP: begin
            if (ctrl_i.laser_off_req) begin
               next_state    = MCST_ST_OFF;
               next_laser_en = 1'b0;
            end else if (tmr + CNT_W'(1) >= START_W) begin
               next_state    = MCST_ST_RUN;
               next_laser_en = 1'b1;
               next_tmr      = '0;
            end
         end
         MCST_ST_RUN: begin
            next_tmr = '0;
            if (fault_seen) begin
               next_state      = MCST_ST_FAULT;
               next_fault_flag = 1'b1;
               next_laser_en   = 1'b0;
            end else if (ctrl_i.laser_off_req) begin
               next_state    = MCST_ST_DISABLE;
               next_laser_en = 1'b0;
            end
         end
         MCST_ST_DISABLE: begin
            next_laser_en = 1'b0;
            if (ctrl_i.laser_off_req) begin
               next_tmr = '0;
            end else if (tmr + CNT_W'(1) >= LASER_ON_W) begin
               next_state    = MCST_ST_RUN;
               next_laser_en = 1'b1;
               next_tmr      = '0;
            end
         end
         MCST_ST_FAULT: begin
            next_laser_en = 1'b0;
            next_tmr      = '0;
            if (fault_reset && !fault_seen) begin
               next_state      = MCST_ST_OFF;
               next_fault_flag = 1'b0;
            end
         end
         default: begin
            next_state    = MCST_ST_OFF;
            next_laser_en = 1'b0;
            next_tmr      = '0;
         end
      endcase
   end

   // Management interface readiness after power-on
   always_comb begin
      next_mgmt_tmr   = mgmt_tmr;
      next_mgmt_ready = mgmt_ready;
      if (!mgmt_ready) begin
         if (mgmt_tmr + CNT_W'(1) >= MGMT_W) begin
            next_mgmt_ready = 1'b1;
         end else begin
            next_mgmt_tmr = mgmt_tmr + CNT_W'(1);
         end
      end
   end

   // Rate select settling: stable flag drops on any change
   always_comb begin
      next_rate_tmr    = rate_tmr;
      next_rate_stable = rate_stable;
      if (rate_q != {ctrl_i.rate_select_high_bit, ctrl_i.rate_select_low_bit}) begin
         next_rate_tmr    = '0;
         next_rate_stable = 1'b0;
      end else if (!rate_stable) begin
         if (rate_tmr + CNT_W'(1) >= (ctrl_i.rate_is_fc ? RATE_FC_W : RATE_OT_W)) begin
            next_rate_stable = 1'b1;
         end else begin
            next_rate_tmr = rate_tmr + CNT_W'(1);
         end
      end
   end

   // Power level transition
   always_comb begin
      next_pwr_tmr = pwr_tmr;
      next_hp_on   = hp_on;
      if (hp_req_q != ctrl_i.high_power_req) begin
         next_pwr_tmr = '0;
      end else if (hp_on != hp_req_q) begin
         if (pwr_tmr + CNT_W'(1) >= (hp_req_q ? HIGH_W : LOW_W)) begin
            next_hp_on   = hp_req_q;
            next_pwr_tmr = '0;
         end else begin
            next_pwr_tmr = pwr_tmr + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state       <= MCST_ST_OFF;
         tmr         <= '0;
         laser_en    <= 1'b0;
         fault_flag  <= 1'b0;
         dis_tmr     <= '0;
         mgmt_tmr    <= '0;
         mgmt_ready  <= 1'b0;
         rate_tmr    <= '0;
         rate_stable <= 1'b0;
         rate_q      <= 2'b00;
         pwr_tmr     <= '0;
         hp_on       <= 1'b0;
         hp_req_q    <= 1'b0;
      end else begin
         state       <= next_state;
         tmr         <= next_tmr;
         laser_en    <= next_laser_en;
         fault_flag  <= next_fault_flag;
         dis_tmr     <= next_dis_tmr;
         mgmt_tmr    <= next_mgmt_tmr;
         mgmt_ready  <= next_mgmt_ready;
         rate_tmr    <= next_rate_tmr;
         rate_stable <= next_rate_stable;
         rate_q      <= {ctrl_i.rate_select_high_bit, ctrl_i.rate_select_low_bit};
         pwr_tmr     <= next_pwr_tmr;
         hp_on       <= next_hp_on;
         hp_req_q    <= ctrl_i.high_power_req;
      end
   end

   always_comb begin
      stat_o.laser_en      = laser_en;
      stat_o.tx_fault      = fault_flag;
      stat_o.rx_los        = los_flag;
      stat_o.mgmt_ready    = mgmt_ready;
      stat_o.module_ready  = (state == MCST_ST_RUN) && (hp_on == hp_req_q);
      stat_o.rate_stable   = rate_stable;
      stat_o.high_power_on = hp_on;
   end

   // Open-drain fault pin: enable low pulls the line low; released means fault
   assign tx_fault_oe_n_o = fault_flag;
endmodule

// ==== verification/mcst_host.sv ====
// Host-side partner: fault-clearing laser-off pulse and pull-up on the fault line
module mcst_host (
   input  wire logic        mclk_i,
   input  wire logic        go_i,
   input  wire logic [31:0] hold_i,
   input  wire logic        tx_fault_oe_n_i,
   output logic             laser_off_o,
   output logic             tx_fault_pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] cnt = 32'h0000_0000;
   // Released line reads high through the host pull-up
   assign tx_fault_pin_o = tx_fault_oe_n_i ? 1'b1 : 1'b0;
   // Request stays up for the whole count asked for, never cut short
   always @(posedge mclk_i) begin
      if (go_i && cnt == 0)
         cnt <= hold_i;
      else if (cnt != 0)
         cnt <= cnt - 1;
   end
   assign laser_off_o = (cnt != 0);
endmodule

// ==== verification/mcst_core_monitor.sv ====
// Checker for the control and status timing block
module mcst_core_monitor
   import mcst_pkg::*;
#(
   parameter bit              COOLED     = 1'b0,
   parameter longint unsigned MGMT_READY = MGMT_READY_CYC,
   parameter longint unsigned HIGH_POWER = HIGH_POWER_CYC,
   parameter longint unsigned LOW_POWER  = LOW_POWER_CYC,
   parameter longint unsigned FAULT_ON   = FAULT_ON_CYC,
   parameter longint unsigned FAULT_COOL = FAULT_COOL_CYC
) (
   input wire logic                 mclk_i,
   input wire logic                 sys_rst_i,
   input wire mcst_pkg::mcst_ctrl_s ctrl_i,
   input wire logic                 laser_fault_i,
   input wire logic                 rx_signal_lost_i,
   input wire mcst_pkg::mcst_stat_s stat_o,
   input wire logic                 tx_fault_oe_n_o
);
   localparam longint unsigned FLT_LIM = (COOLED ? FAULT_COOL : FAULT_ON) + 3;
   localparam longint unsigned PW_LIM  = (HIGH_POWER > LOW_POWER ? HIGH_POWER : LOW_POWER) + 3;
   localparam longint unsigned LOS_LIM = (LOS_ON_CYC > LOS_OFF_CYC ? LOS_ON_CYC : LOS_OFF_CYC) + 3;
   longint unsigned up_cnt, flt_cnt, pw_cnt, los_cnt;
   longint unsigned next_up_cnt, next_flt_cnt, next_pw_cnt, next_los_cnt;
   // Fault age counts only once the laser was running when it began
   always_comb begin
      next_up_cnt  = (up_cnt < MGMT_READY + 3) ? up_cnt + 1 : up_cnt;
      next_flt_cnt = (laser_fault_i && (stat_o.laser_en || flt_cnt != 0)) ? flt_cnt + 1 : 0;
      next_pw_cnt  = (ctrl_i.high_power_req != stat_o.high_power_on) ? pw_cnt + 1 : 0;
      next_los_cnt = (rx_signal_lost_i != stat_o.rx_los) ? los_cnt + 1 : 0;
   end
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         up_cnt  <= 0;
         flt_cnt <= 0;
         pw_cnt  <= 0;
         los_cnt <= 0;
      end else begin
         up_cnt  <= next_up_cnt;
         flt_cnt <= next_flt_cnt;
         pw_cnt  <= next_pw_cnt;
         los_cnt <= next_los_cnt;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   chk_off_fast: assert property ($rose(ctrl_i.laser_off_req) |-> ##[1:3] !stat_o.laser_en)
      else $error("laser still on after off request");
   chk_off_hold: assert property (ctrl_i.laser_off_req && $past(ctrl_i.laser_off_req, 2) |-> !stat_o.laser_en)
      else $error("laser on while off request held");
   chk_fault_latch: assert property (stat_o.tx_fault && !ctrl_i.laser_off_req |=> stat_o.tx_fault)
      else $error("fault flag dropped without clear pulse");
   chk_fault_dark: assert property (stat_o.tx_fault |-> !stat_o.laser_en)
      else $error("laser on while fault latched");
   chk_fault_pin: assert property (tx_fault_oe_n_o == stat_o.tx_fault)
      else $error("fault pin disagrees with fault flag");
   chk_fault_time: assert property (flt_cnt == FLT_LIM |-> stat_o.tx_fault)
      else $error("fault flag late");
   chk_mgmt_time: assert property (up_cnt == MGMT_READY + 3 |-> stat_o.mgmt_ready)
      else $error("management interface late");
   chk_rate_drop: assert property (
      $changed({ctrl_i.rate_select_low_bit, ctrl_i.rate_select_high_bit}) |=> !stat_o.rate_stable)
      else $error("rate stable kept across rate change");
   chk_power_time: assert property (pw_cnt <= PW_LIM)
      else $error("power level change late");
   chk_los_time: assert property (los_cnt <= LOS_LIM)
      else $error("loss flag late");
endmodule

bind mcst_core mcst_core_monitor #(.COOLED(COOLED), .MGMT_READY(MGMT_READY), .HIGH_POWER(HIGH_POWER),
   .LOW_POWER(LOW_POWER), .FAULT_ON(FAULT_ON), .FAULT_COOL(FAULT_COOL)) u_mon (.mclk_i(mclk_i),
   .sys_rst_i(sys_rst_i), .ctrl_i(ctrl_i), .laser_fault_i(laser_fault_i), .rx_signal_lost_i(rx_signal_lost_i),
   .stat_o(stat_o), .tx_fault_oe_n_o(tx_fault_oe_n_o));

// ==== verification/tb_mcst_core.sv ====
// Testbench for the control and status timing block
module tb_mcst_core;
   timeunit 1ns;
   timeprecision 1ps;
   import mcst_pkg::*;
   localparam int P_LON = 30, P_MR = 40, P_SU = 50, P_HP = 60, P_FO = 10, P_RO = 25, P_SC = 80, P_FC = 15;
   localparam logic [7:0] PIN = 8'h80, LEN = 8'h40, TXF = 8'h20, LOS = 8'h10;
   localparam logic [7:0] MGR = 8'h08, MRD = 8'h04, RST = 8'h02, HPO = 8'h01;
   logic        mclk_i, sys_rst_i, laser_fault_i, rx_signal_lost_i, tx_fault_oe_n_o;
   logic        tx_pin, host_off, host_go, tb_off, rsl, rsh, rfc, hpr;
   logic [31:0] hold;
   logic [16:0] note;
   logic [16:0] notes[$];
   logic        tx_oe_c;
   mcst_stat_s  stat_c;
   int          err_count, n_tests, k;
   mcst_ctrl_s  ctrl;
   mcst_stat_s  stat;
   event        chk_ev;
   assign ctrl = '{tb_off | host_off, rsl, rsh, rfc, hpr};
   mcst_core #(.COOLED(1'b0), .LASER_ON(P_LON), .MGMT_READY(P_MR), .STARTUP(P_SU), .STARTUP_COOL(80),
      .HIGH_POWER(P_HP), .LOW_POWER(P_HP), .FAULT_ON(P_FO), .FAULT_COOL(15), .RATE_OTHER(P_RO)) uut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ctrl_i(ctrl), .laser_fault_i(laser_fault_i),
      .rx_signal_lost_i(rx_signal_lost_i), .stat_o(stat), .tx_fault_oe_n_o(tx_fault_oe_n_o));
   // Cooled variant on the same pins, to show its longer start-up and fault times
   mcst_core #(.COOLED(1'b1), .LASER_ON(P_LON), .MGMT_READY(P_MR), .STARTUP(P_SU), .STARTUP_COOL(P_SC),
      .HIGH_POWER(P_HP), .LOW_POWER(P_HP), .FAULT_ON(P_FO), .FAULT_COOL(P_FC), .RATE_OTHER(P_RO)) uut_cool (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ctrl_i(ctrl), .laser_fault_i(laser_fault_i),
      .rx_signal_lost_i(rx_signal_lost_i), .stat_o(stat_c), .tx_fault_oe_n_o(tx_oe_c));
   mcst_host u_host (.mclk_i(mclk_i), .go_i(host_go), .hold_i(hold), .tx_fault_oe_n_i(tx_fault_oe_n_o),
      .laser_off_o(host_off), .tx_fault_pin_o(tx_pin));
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask
   // Selector c picks the cooled instance
   task automatic expect_st(input logic [7:0] m, input logic [7:0] v, input bit c = 1'b0);
      notes.push_back({c, m, v});
      ->chk_ev;
   endtask
   task automatic cmp_st(input logic [7:0] m, input logic [7:0] v, input logic [7:0] w);
      n_tests++;
      if ((w & m) !== v) begin
         err_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, w & m, v);
      end
   endtask
   // Host clear pulse through the partner, then wait it out
   task automatic pulse(input int n);
      hold = n;
      host_go = 1'b1;
      cyc(1);
      host_go = 1'b0;
      cyc(n + 2);
   endtask
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial forever begin
      @(chk_ev);
      while (notes.size() > 0) begin
         note = notes.pop_front();
         cmp_st(note[15:8], note[7:0], note[16] ? {tx_oe_c, stat_c} : {tx_pin, stat});
      end
   end
   initial begin
      #(5ns * 70000);
      err_count++;
      wrap_up();
   end
   initial begin
      {sys_rst_i, laser_fault_i, rx_signal_lost_i, tb_off, rsl, rsh, rfc, hpr, host_go} = 9'h100;
      hold = 32'h0000_0000;
      err_count = 0;
      n_tests = 0;
      void'($urandom(21));
      cyc(4);
      expect_st(8'hff, 8'h00);
      sys_rst_i = 1'b0;
      cyc(P_MR - 3);
      expect_st(MGR | LOS, LOS);
      cyc(6);
      expect_st(MGR, MGR);
      cyc(P_SU - P_MR - 6);
      expect_st(LEN, 8'h00);
      cyc(6);
      expect_st(LEN | MGR | MRD, LEN | MGR | MRD);
      expect_st(LEN, 8'h00, 1'b1);
      tb_off = 1'b1;
      cyc(3);
      expect_st(LEN, 8'h00);
      cyc(20 + $urandom % 40);
      expect_st(LEN, 8'h00);
      tb_off = 1'b0;
      cyc(P_LON - 3);
      expect_st(LEN, 8'h00);
      cyc(6);
      expect_st(LEN | MRD, LEN | MRD);
      expect_st(LEN, 8'h00, 1'b1);
      for (k = 0; k < 4; k++) begin
         {rsh, rsl} = {rsh, rsl} + 2'(1 + $urandom % 3);
         cyc(2);
         expect_st(RST, 8'h00);
         cyc(P_RO + 2);
         expect_st(RST, RST);
      end
      expect_st(LEN, LEN, 1'b1);
      hpr = 1'b1;
      cyc(3);
      expect_st(HPO | MRD, 8'h00);
      cyc(P_HP);
      expect_st(HPO | MRD, HPO | MRD);
      hpr = 1'b0;
      cyc(3);
      expect_st(HPO | MRD, HPO);
      cyc(P_HP);
      expect_st(HPO | MRD, MRD);
      laser_fault_i = 1'b1;
      cyc(P_FO - 3);
      laser_fault_i = 1'b0;
      cyc(3);
      expect_st(TXF | PIN | LEN, LEN);
      laser_fault_i = 1'b1;
      cyc(P_FO + 3);
      expect_st(TXF | PIN | LEN, TXF | PIN);
      expect_st(TXF | PIN | LEN, LEN, 1'b1);
      cyc(P_FC - P_FO + 2);
      expect_st(TXF | PIN | LEN, TXF | PIN, 1'b1);
      laser_fault_i = 1'b0;
      cyc(10 + $urandom % 40);
      expect_st(TXF | LEN, TXF);
      pulse(int'(FAULT_RESET_CYC) / 2);
      expect_st(TXF, TXF);
      pulse(int'(FAULT_RESET_CYC) + 5);
      expect_st(TXF | PIN | LEN, 8'h00);
      expect_st(TXF | PIN, 8'h00, 1'b1);
      cyc(P_SU + 3);
      expect_st(LEN, LEN);
      expect_st(LEN, 8'h00, 1'b1);
      rfc = 1'b1;
      rsl = ~rsl;
      cyc(2);
      expect_st(RST, 8'h00);
      cyc(P_RO + 5);
      expect_st(RST, 8'h00);
      rfc = 1'b0;
      cyc(int'(LOS_OFF_CYC));
      expect_st(LOS, 8'h00);
      rx_signal_lost_i = 1'b1;
      cyc(100);
      rx_signal_lost_i = 1'b0;
      cyc(3);
      expect_st(LOS, 8'h00);
      rx_signal_lost_i = 1'b1;
      cyc(int'(LOS_ON_CYC) - 5);
      expect_st(LOS, 8'h00);
      cyc(10);
      expect_st(LOS, LOS);
      expect_st(LEN, LEN, 1'b1);
      cyc(2);
      wrap_up();
   end
endmodule
